// ---- rtl/dstp_bucket.sv ----
`timescale 1ns/1ps
`include "dstp_consts.svh"
// One token bucket: refill each tick, test and deduct on request
module dstp_bucket #(
   parameter int BW = 24
) (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic tick_i,
   input wire logic [15:0] rate_i,
   input wire logic [BW-1:0] depth_i,
   input wire logic [15:0] len_i,
   input wire logic take_i,
   output logic ok_o
);
   logic [BW-1:0] fill_q;
   logic [BW:0] sum;
   logic [BW-1:0] after_take;

   // Enough tokens for the packet
   assign ok_o = fill_q >= {{(BW-16){1'b0}}, len_i};
   assign after_take = take_i ? fill_q - {{(BW-16){1'b0}}, len_i} : fill_q;
   assign sum = {1'b0, after_take} + {{(BW-15){1'b0}}, rate_i};

   // Refill saturates at depth so an idle port cannot bank unlimited burst
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fill_q <= `DSTP_RST_BUCKET;
      end else if (tick_i && sum > {1'b0, depth_i}) begin
         fill_q <= depth_i;
      end else if (tick_i) begin
         fill_q <= sum[BW-1:0];
      end else begin
         fill_q <= after_take;
      end
   end
endmodule : dstp_bucket

// ---- rtl/dstp_consts.svh ----
`ifndef DSTP_CONSTS_SVH
`define DSTP_CONSTS_SVH
// Register word offsets (byte address = index * 4)
`define DSTP_REG_GLOBAL 4'h0
`define DSTP_REG_ALLPORT 4'h1
`define DSTP_REG_PSEL 4'h2
`define DSTP_REG_PCTRL 4'h3
`define DSTP_REG_CIR 4'h4
`define DSTP_REG_PIR 4'h5
`define DSTP_REG_DSCP 4'h6
`define DSTP_REG_STAT 4'h7
// Global control bit positions
`define DSTP_GBIT_DSEN 0
`define DSTP_GBIT_MKEN 1
`define DSTP_GBIT_AWARE 2
`define DSTP_GBIT_BWEN 3
// Port control bit positions
`define DSTP_PBIT_DSEN 0
`define DSTP_PBIT_MKEN 1
// Code point field layout in the service octet
`define DSTP_DSCP_MSB 7
`define DSTP_DSCP_LSB 2
// Reset values
`define DSTP_RST_GLOBAL 4'h0
`define DSTP_RST_RATE 16'h0001
`define DSTP_RST_BUCKET 24'h000000
// Refill period in clock cycles
`define DSTP_REFILL_CYC 16'h03E8
`endif

// ---- rtl/dstp_pkg.sv ----
package dstp_pkg;
   typedef enum logic [1:0] {
      DSTP_GREEN = 2'h0,
      DSTP_YELLOW = 2'h1,
      DSTP_RED = 2'h2,
      DSTP_NONE = 2'h3
   } dstp_color_t;
   typedef enum logic [1:0] {
      DSTP_ST_IDLE = 2'h0,
      DSTP_ST_LOOK = 2'h1,
      DSTP_ST_OUT = 2'h2
   } dstp_state_t;
endpackage : dstp_pkg

// ---- rtl/dstp_policer.sv ----
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "dstp_consts.svh"
module dstp_policer #(
   parameter int NPORT = 4,
   parameter int BW = 24,
   parameter logic [23:0] DEPTH = 24'h00FFFF
) (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic pkt_valid_i,
   output logic pkt_ready_o,
   input wire logic [$clog2(NPORT)-1:0] pkt_port_i,
   input wire logic [7:0] pkt_tos_i,
   input wire logic [1:0] pkt_color_i,
   input wire logic [15:0] pkt_len_i,
   input wire logic congest_i,
   output logic out_valid_o,
   output logic [$clog2(NPORT)-1:0] out_port_o,
   output logic [7:0] out_tos_o,
   output logic [1:0] out_color_o,
   output logic out_drop_o
);
   localparam int PW = $clog2(NPORT);

   ////////////////////////////////////////////////////////////////////////
   // Register bus
   logic [3:0] glob_q;
   logic [PW-1:0] psel_q;
   logic [NPORT-1:0] pds_q, pmk_q;
   logic [15:0] cir_q [NPORT];
   logic [15:0] pir_q [NPORT];
   logic [17:0] dscp_q [NPORT];
   logic [31:0] cnt_fwd_q, cnt_drop_q;
   logic [31:0] rdata_d;
   logic wr_ack_q, rd_ack_q;
   logic [3:0] widx;
   logic wr_go, bw_refused_q;
   logic congest_s1_q, congest_s2_q;

   assign widx = avs_address_i[5:2];
   // One wait cycle on every access keeps read data registered
   assign avs_waitrequest_o = (avs_read_i && !rd_ack_q) || (avs_write_i && !wr_ack_q);
   assign wr_go = avs_write_i && wr_ack_q && avs_byteenable_i[0]; // Lands as waitrequest drops

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ack_q <= 1'b0;
         rd_ack_q <= 1'b0;
      end else begin
         wr_ack_q <= avs_write_i && !wr_ack_q;
         rd_ack_q <= avs_read_i && !rd_ack_q;
      end
   end

   // Global control; refuse marker together with bandwidth control
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         glob_q <= `DSTP_RST_GLOBAL;
         bw_refused_q <= 1'b0;
      end else if (wr_go && widx == `DSTP_REG_GLOBAL) begin
         if (avs_writedata_i[`DSTP_GBIT_MKEN] && avs_writedata_i[`DSTP_GBIT_BWEN]) begin
            bw_refused_q <= 1'b1;
            glob_q <= {1'b0, avs_writedata_i[2:0]};
         end else begin
            bw_refused_q <= 1'b0;
            glob_q <= avs_writedata_i[3:0];
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         psel_q <= '0;
      end else if (wr_go && widx == `DSTP_REG_PSEL) begin
         psel_q <= avs_writedata_i[PW-1:0];
      end
   end

   // Per-port settings; all-ports entry broadcasts into every port
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pds_q <= '0;
         pmk_q <= '0;
         for (int i = 0; i < NPORT; i++) begin
            cir_q[i] <= `DSTP_RST_RATE;
            pir_q[i] <= `DSTP_RST_RATE;
            dscp_q[i] <= 18'h00000;
         end
      end else if (wr_go) begin
         for (int i = 0; i < NPORT; i++) begin
            if (widx == `DSTP_REG_ALLPORT) begin
               pds_q[i] <= avs_writedata_i[`DSTP_PBIT_DSEN];
               pmk_q[i] <= avs_writedata_i[`DSTP_PBIT_MKEN];
            end else if (PW'(i) == psel_q) begin
               case (widx)
                  `DSTP_REG_PCTRL: begin
                     pds_q[i] <= avs_writedata_i[`DSTP_PBIT_DSEN];
                     pmk_q[i] <= avs_writedata_i[`DSTP_PBIT_MKEN];
                  end
                  `DSTP_REG_CIR: cir_q[i] <= avs_writedata_i[15:0];
                  `DSTP_REG_PIR: pir_q[i] <= avs_writedata_i[15:0];
                  `DSTP_REG_DSCP: dscp_q[i] <= avs_writedata_i[17:0];
                  default: ;
               endcase
            end
         end
      end
   end

   // Read mux; unmapped words read zero
   always_comb begin
      rdata_d = 32'h00000000;
      case (widx)
         `DSTP_REG_GLOBAL: rdata_d = {27'h0, bw_refused_q, glob_q};
         `DSTP_REG_PSEL: rdata_d = {{(32-PW){1'b0}}, psel_q};
         `DSTP_REG_PCTRL: rdata_d = {30'h0, pmk_q[psel_q], pds_q[psel_q]};
         `DSTP_REG_CIR: rdata_d = {16'h0, cir_q[psel_q]};
         `DSTP_REG_PIR: rdata_d = {16'h0, pir_q[psel_q]};
         `DSTP_REG_DSCP: rdata_d = {14'h0, dscp_q[psel_q]};
         `DSTP_REG_STAT: rdata_d = {cnt_drop_q[15:0], cnt_fwd_q[15:0]};
         default: rdata_d = 32'h00000000;
      endcase
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         avs_readdata_o <= 32'h00000000;
      end else if (avs_read_i && !rd_ack_q) begin
         avs_readdata_o <= rdata_d;
      end
   end

   // Congestion is a level from another domain
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         congest_s1_q <= 1'b0;
         congest_s2_q <= 1'b0;
      end else begin
         congest_s1_q <= congest_i;
         congest_s2_q <= congest_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Token buckets
   logic [15:0] tick_cnt_q;
   logic tick;
   logic [NPORT-1:0] cok, pok, ctake, ptake;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_cnt_q <= 16'h0000;
      end else if (tick) begin
         tick_cnt_q <= 16'h0000;
      end else begin
         tick_cnt_q <= tick_cnt_q + 16'h0001;
      end
   end
   assign tick = tick_cnt_q == `DSTP_REFILL_CYC - 16'h0001;

   ////////////////////////////////////////////////////////////////////////
   // Packet pipeline: take, judge, present
   dstp_pkg::dstp_state_t st_q;
   logic [PW-1:0] port_q;
   logic [7:0] tos_q;
   logic [1:0] icol_q;
   logic [15:0] len_q;
   dstp_pkg::dstp_color_t col_d;
   logic mark_on, aware, dsen;
   logic take_c, take_p;

   assign pkt_ready_o = st_q == dstp_pkg::DSTP_ST_IDLE;
   assign aware = glob_q[`DSTP_GBIT_AWARE];
   assign mark_on = glob_q[`DSTP_GBIT_MKEN] && pmk_q[port_q];
   assign dsen = glob_q[`DSTP_GBIT_DSEN] && pds_q[port_q];

   genvar g;
   generate
      for (g = 0; g < NPORT; g++) begin : g_port
         assign ctake[g] = take_c && port_q == PW'(g);
         assign ptake[g] = take_p && port_q == PW'(g);
         dstp_bucket #(.BW(BW)) u_cir (
            .clock_i(clock_i),
            .rstn_i(rstn_i),
            .tick_i(tick),
            .rate_i(cir_q[g]),
            .depth_i(DEPTH),
            .len_i(len_q),
            .take_i(ctake[g]),
            .ok_o(cok[g])
         );
         dstp_bucket #(.BW(BW)) u_pir (
            .clock_i(clock_i),
            .rstn_i(rstn_i),
            .tick_i(tick),
            .rate_i(pir_q[g]),
            .depth_i(DEPTH),
            .len_i(len_q),
            .take_i(ptake[g]),
            .ok_o(pok[g])
         );
      end
   endgenerate

   // Colour decision; peak first, then committed
   always_comb begin
      col_d = dstp_pkg::dstp_color_t'(icol_q);
      take_c = 1'b0;
      take_p = 1'b0;
      if (aware && icol_q == dstp_pkg::DSTP_NONE) begin
         col_d = dstp_pkg::DSTP_NONE;
      end else if (aware && icol_q == dstp_pkg::DSTP_RED) begin
         col_d = dstp_pkg::DSTP_RED;
      end else if (!pok[port_q]) begin
         col_d = dstp_pkg::DSTP_RED;
      end else if (aware && icol_q == dstp_pkg::DSTP_YELLOW) begin
         col_d = dstp_pkg::DSTP_YELLOW;
         take_p = 1'b1;
      end else if (!cok[port_q]) begin
         col_d = dstp_pkg::DSTP_YELLOW;
         take_p = 1'b1;
      end else begin
         col_d = dstp_pkg::DSTP_GREEN;
         take_p = 1'b1;
         take_c = 1'b1;
      end
      // Deduct only in the judging cycle of an enabled port
      if (!(st_q == dstp_pkg::DSTP_ST_LOOK && mark_on && dsen)) begin
         take_c = 1'b0;
         take_p = 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q <= dstp_pkg::DSTP_ST_IDLE;
      end else begin
         case (st_q)
            dstp_pkg::DSTP_ST_IDLE: if (pkt_valid_i) st_q <= dstp_pkg::DSTP_ST_LOOK;
            dstp_pkg::DSTP_ST_LOOK: st_q <= dstp_pkg::DSTP_ST_OUT;
            dstp_pkg::DSTP_ST_OUT: st_q <= dstp_pkg::DSTP_ST_IDLE;
            default: st_q <= dstp_pkg::DSTP_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         port_q <= '0;
         tos_q <= 8'h00;
         icol_q <= 2'h0;
         len_q <= 16'h0000;
      end else if (pkt_valid_i && pkt_ready_o) begin
         port_q <= pkt_port_i;
         tos_q <= pkt_tos_i;
         icol_q <= pkt_color_i;
         len_q <= pkt_len_i;
      end
   end

   // Result: rewrite code point, keep unused bits, decide drop
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_tos_o <= 8'h00;
         out_color_o <= 2'h0;
         out_drop_o <= 1'b0;
         out_port_o <= '0;
      end else if (st_q == dstp_pkg::DSTP_ST_LOOK) begin
         out_port_o <= port_q;
         out_tos_o <= tos_q;
         out_color_o <= icol_q;
         out_drop_o <= 1'b0;
         if (mark_on && dsen && col_d != dstp_pkg::DSTP_NONE) begin
            out_color_o <= col_d;
            case (col_d)
               dstp_pkg::DSTP_GREEN: begin
                  out_tos_o <= {dscp_q[port_q][5:0], tos_q[1:0]};
                  out_drop_o <= 1'b0;
               end
               dstp_pkg::DSTP_YELLOW: begin
                  out_tos_o <= {dscp_q[port_q][11:6], tos_q[1:0]};
                  out_drop_o <= congest_s2_q;
               end
               default: begin
                  out_tos_o <= {dscp_q[port_q][17:12], tos_q[1:0]};
                  out_drop_o <= 1'b1;
               end
            endcase
         end
      end
   end

   assign out_valid_o = st_q == dstp_pkg::DSTP_ST_OUT;

   // Forward and drop counters
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_fwd_q <= 32'h00000000;
         cnt_drop_q <= 32'h00000000;
      end else if (out_valid_o && out_drop_o) begin
         cnt_drop_q <= cnt_drop_q + 32'h00000001;
      end else if (out_valid_o) begin
         cnt_fwd_q <= cnt_fwd_q + 32'h00000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_judge_red;
      st_q == dstp_pkg::DSTP_ST_LOOK && mark_on && dsen && col_d == dstp_pkg::DSTP_RED;
   endsequence

   a_red_dropped: assert property (@(posedge clock_i) disable iff (!rstn_i)
      s_judge_red |=> out_valid_o && out_drop_o)
      else $error("red packet not dropped");
   a_green_kept: assert property (@(posedge clock_i) disable iff (!rstn_i)
      out_valid_o && out_color_o == 2'h0 |-> !out_drop_o)
      else $error("green packet dropped");
   a_yellow_congest: assert property (@(posedge clock_i) disable iff (!rstn_i)
      st_q == dstp_pkg::DSTP_ST_LOOK && mark_on && dsen && col_d == dstp_pkg::DSTP_YELLOW
      |=> out_drop_o == $past(congest_s2_q))
      else $error("yellow drop mismatch");
   a_aware_red_stays: assert property (@(posedge clock_i) disable iff (!rstn_i)
      st_q == dstp_pkg::DSTP_ST_LOOK && aware && icol_q == 2'h2 |=> out_color_o == 2'h2)
      else $error("aware red changed");
   a_no_lower: assert property (@(posedge clock_i) disable iff (!rstn_i)
      st_q == dstp_pkg::DSTP_ST_LOOK && aware && icol_q != 2'h3 |=> out_color_o >= $past(icol_q))
      else $error("loss priority lowered");
   a_unmarked_pass: assert property (@(posedge clock_i) disable iff (!rstn_i)
      st_q == dstp_pkg::DSTP_ST_LOOK && aware && icol_q == 2'h3 |=> out_tos_o == $past(tos_q))
      else $error("unmarked packet altered");
   a_off_no_drop: assert property (@(posedge clock_i) disable iff (!rstn_i)
      st_q == dstp_pkg::DSTP_ST_LOOK && !glob_q[`DSTP_GBIT_DSEN] |=> !out_drop_o)
      else $error("drop while disabled");
   a_cu_kept: assert property (@(posedge clock_i) disable iff (!rstn_i)
      st_q == dstp_pkg::DSTP_ST_LOOK |=> out_tos_o[1:0] == $past(tos_q[1:0]))
      else $error("unused bits changed");
   a_no_both_on: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !(glob_q[`DSTP_GBIT_MKEN] && glob_q[`DSTP_GBIT_BWEN]))
      else $error("marker with bandwidth control");
   a_peak_first: assert property (@(posedge clock_i) disable iff (!rstn_i)
      st_q == dstp_pkg::DSTP_ST_LOOK && !aware && !pok[port_q] |-> col_d == dstp_pkg::DSTP_RED)
      else $error("peak exceed not red");
endmodule : dstp_policer

// ---- testbench/dstp_pkt_src.sv ----
`timescale 1ns/1ps
// Ingress port model: offers one packet, holds it until the policer takes it
module dstp_pkt_src (
   input wire logic clock_i,
   input wire logic ready_i,
   output logic valid_o,
   output logic [1:0] port_o,
   output logic [7:0] tos_o,
   output logic [1:0] color_o,
   output logic [15:0] len_o
);
   // Quiet port at time zero
   initial begin
      valid_o = 1'b0;
      port_o = 2'h0;
      tos_o = 8'h00;
      color_o = 2'h0;
      len_o = 16'h0000;
   end
   // Offer after gap idle cycles; released lines show the inverse, never a stale copy
   task automatic send(input int gap, input logic [1:0] p, input logic [7:0] t,
                       input logic [1:0] c, input logic [15:0] l);
      repeat (gap) @(posedge clock_i);
      @(posedge clock_i);
      valid_o <= 1'b1;
      port_o <= p;
      tos_o <= t;
      color_o <= c;
      len_o <= l;
      @(posedge clock_i);
      while (ready_i !== 1'b1) @(posedge clock_i);
      valid_o <= 1'b0;
      port_o <= ~p;
      tos_o <= ~t;
      color_o <= ~c;
      len_o <= ~l;
   endtask : send
endmodule : dstp_pkt_src

// ---- testbench/test_diffserv_two_rate_color_policer.sv ----
`timescale 1ns/1ps
module test_diffserv_two_rate_color_policer;
   logic clock;
   logic rst_n;
   logic [5:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [3:0] byteenable;
   logic [31:0] readdata;
   logic waitrequest;
   logic pkt_valid;
   logic pkt_ready;
   logic [1:0] pkt_port;
   logic [7:0] pkt_tos;
   logic [1:0] pkt_color;
   logic [15:0] pkt_len;
   logic congest;
   logic out_valid;
   logic [1:0] out_port;
   logic [7:0] out_tos;
   logic [1:0] out_color;
   logic out_drop;
   logic [31:0] rd;
   int mismatches = 0;
   int checked = 0;
   int cyc = 0;
   // Code points for green, yellow, red; service octet with legacy bits set
   localparam logic [5:0] CG = 6'h0A;
   localparam logic [5:0] CY = 6'h12;
   localparam logic [5:0] CR = 6'h2E;
   localparam logic [7:0] TOS_IN = 8'hE3;

   dstp_policer dut_u (
      .clock_i(clock), .rstn_i(rst_n), .avs_address_i(address), .avs_read_i(read),
      .avs_write_i(write), .avs_writedata_i(writedata), .avs_byteenable_i(byteenable),
      .avs_readdata_o(readdata), .avs_waitrequest_o(waitrequest),
      .pkt_valid_i(pkt_valid), .pkt_ready_o(pkt_ready), .pkt_port_i(pkt_port),
      .pkt_tos_i(pkt_tos), .pkt_color_i(pkt_color), .pkt_len_i(pkt_len),
      .congest_i(congest), .out_valid_o(out_valid), .out_port_o(out_port),
      .out_tos_o(out_tos), .out_color_o(out_color), .out_drop_o(out_drop)
   );
   dstp_pkt_src src_u (
      .clock_i(clock), .ready_i(pkt_ready), .valid_o(pkt_valid), .port_o(pkt_port),
      .tos_o(pkt_tos), .color_o(pkt_color), .len_o(pkt_len)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clock, 100 ns period
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // Cycle count; also cuts a hang short
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         mismatches++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Bus write: held until waitrequest is seen low at an edge
   task automatic bus_wr(input logic [3:0] idx, input logic [31:0] d, input logic [3:0] be);
      @(posedge clock);
      address <= {idx, 2'b00};
      writedata <= d;
      byteenable <= be;
      write <= 1'b1;
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      write <= 1'b0;
   endtask : bus_wr
   // Bus read: data taken at the same edge as waitrequest low
   task automatic bus_rd(input logic [3:0] idx);
      @(posedge clock);
      address <= {idx, 2'b00};
      read <= 1'b1;
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      rd = readdata;
      read <= 1'b0;
   endtask : bus_rd
   // Marked octet keeps the two unused low bits of the arrival
   function automatic logic [7:0] mk(input logic [1:0] c);
      return {(c == 2'h0) ? CG : (c == 2'h1) ? CY : CR, TOS_IN[1:0]};
   endfunction : mk
   // One packet through; result judged at the out_valid pulse
   task automatic pkt(input int gap, input logic [1:0] p, input logic [1:0] c,
                      input logic [15:0] l, input logic [1:0] ec, input logic ed,
                      input logic [7:0] et);
      int n;
      src_u.send(gap, p, TOS_IN, c, l);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (out_valid !== 1'b1 && n < 10);
      chk("out_valid", 32'h1, {31'h0, out_valid});
      chk("out_port", {30'h0, p}, {30'h0, out_port});
      chk("out_color", {30'h0, ec}, {30'h0, out_color});
      chk("out_drop", {31'h0, ed}, {31'h0, out_drop});
      chk("out_tos", {24'h0, et}, {24'h0, out_tos});
   endtask : pkt

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence; rates 100 and 200 tokens per refill on port 0
   initial begin
      rst_n = 1'b0;
      address = 6'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h00000000;
      byteenable = 4'hF;
      congest = 1'b0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      bus_rd(4'h0);
      chk("global reset", 32'h00000000, rd);
      bus_wr(4'h2, 32'h00000000, 4'hF);
      bus_rd(4'h4);
      chk("cir reset", 32'h00000001, rd);
      bus_wr(4'h9, 32'hFFFFFFFF, 4'hF);
      bus_rd(4'h9);
      chk("unmapped", 32'h00000000, rd);
      bus_wr(4'h4, 32'h00000064, 4'hF);
      bus_wr(4'h5, 32'h000000C8, 4'hF);
      bus_wr(4'h6, 32'h0002E48A, 4'hF);
      bus_wr(4'h4, 32'h00000005, 4'h0);
      bus_rd(4'h4);
      chk("cir lane off", 32'h00000064, rd);
      bus_wr(4'h1, 32'h00000003, 4'hF);
      bus_wr(4'h2, 32'h00000001, 4'hF);
      bus_rd(4'h3);
      chk("allport copy", 32'h00000003, rd);
      bus_wr(4'h3, 32'h00000000, 4'hF);
      bus_rd(4'h3);
      chk("port override", 32'h00000000, rd);
      bus_wr(4'h2, 32'h00000000, 4'hF);
      pkt(0, 2'h0, 2'h1, 16'h0064, 2'h1, 1'b0, TOS_IN);
      bus_wr(4'h0, 32'h0000000B, 4'hF);
      bus_rd(4'h0);
      chk("marker and bandwidth", 32'h00000013, rd);
      bus_wr(4'h0, 32'h00000003, 4'hF);
      bus_rd(4'h0);
      chk("global blind", 32'h00000003, rd);
      pkt(0, 2'h1, 2'h2, 16'h000A, 2'h2, 1'b0, TOS_IN);
      // First refill lands near cycle 1006; buckets then hold 100 and 200
      while (cyc < 1060) @(posedge clock);
      pkt(2, 2'h0, 2'h2, 16'h003C, 2'h0, 1'b0, mk(2'h0));
      pkt(0, 2'h0, 2'h0, 16'h0032, 2'h1, 1'b0, mk(2'h1));
      pkt(0, 2'h0, 2'h0, 16'h0064, 2'h2, 1'b1, mk(2'h2));
      pkt(1, 2'h0, 2'h1, 16'h0028, 2'h0, 1'b0, mk(2'h0));
      congest <= 1'b1;
      repeat (4) @(posedge clock);
      pkt(0, 2'h0, 2'h0, 16'h0032, 2'h1, 1'b1, mk(2'h1));
      congest <= 1'b0;
      bus_wr(4'h0, 32'h00000007, 4'hF);
      // Second refill: buckets back to 100 and 200
      while (cyc < 2060) @(posedge clock);
      pkt(0, 2'h0, 2'h2, 16'h000A, 2'h2, 1'b1, mk(2'h2));
      pkt(0, 2'h0, 2'h1, 16'h0096, 2'h1, 1'b0, mk(2'h1));
      pkt(0, 2'h0, 2'h1, 16'h003C, 2'h2, 1'b1, mk(2'h2));
      pkt(0, 2'h0, 2'h0, 16'h0032, 2'h0, 1'b0, mk(2'h0));
      pkt(0, 2'h0, 2'h0, 16'h000A, 2'h2, 1'b1, mk(2'h2));
      pkt(0, 2'h0, 2'h3, 16'h000A, 2'h3, 1'b0, TOS_IN);
      // Thirteen packets so far: five dropped, eight forwarded
      bus_rd(4'h7);
      chk("stat counts", 32'h00050008, rd);
      stop_test();
   end
endmodule : test_diffserv_two_rate_color_policer
